// ==== sms_map.svh ====
// Register offsets, reset values, timing figures and fault cause codes.
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH
`define SMS_ADDR_CTRL     12'h000
`define SMS_ADDR_FAULT    12'h004
`define SMS_ADDR_STATUS   12'h008
`define SMS_CTRL_RST      32'h0000_0101
`define SMS_CTRL_VALID    8
`define SMS_CLK_NS        5
`define SMS_TICK_NS       1_000_000
`define SMS_SYNC_MS       16'd5000
`define SMS_CFG_MS        16'd30000
`define SMS_ACT_MIN_MS    16'd30
`define SMS_ACT_MAX_MS    16'd3000
`define SMS_QUICK_MS      16'd125
`define SMS_SLOW_MS       16'd500
`define SMS_TEST_MS       16'd500
`define SMS_LONG_MS       16'd600
`define SMS_SHORT_MS      16'd200
`define SMS_GAP_MS        16'd300
`define SMS_GROUP_MS      16'd1000
`define SMS_PAUSE_MS      16'd3000
`define SMS_MODE_CFG      4'hC
`define SMS_MODE_MON_MAX  4'h5
`define SMS_MODE_MAX      4'hA
`define SMS_DLY_TAB {16'd30000, 16'd25000, 16'd20000, 16'd15000, \
  16'd12000, 16'd10000, 16'd8500, 16'd5000, 16'd4000, 16'd3000, \
  16'd2500, 16'd2000, 16'd1500, 16'd1000, 16'd500, 16'd0}
`define SMS_F_UV          5'h01
`define SMS_F_OV          5'h02
`define SMS_F_SEL         5'h03
`define SMS_F_XW          5'h0B
`define SMS_F_CFG         5'h11
`define SMS_F_LAST        5'h11
`endif

// ==== sms_pkg.sv ====
// Types shared by the safety monitor status and start logic.
package sms_pkg;
  typedef enum logic [2:0] {
    ST_TEST, ST_IDLE, ST_RUN, ST_DROP, ST_CHANGED, ST_FAULT
  } sms_state_e;
  typedef enum logic [1:0] {
    FL_LONG_ON, FL_LONG_OFF, FL_SHORT_ON, FL_SHORT_OFF
  } sms_flash_e;
endpackage

// ==== sms_top.sv ====
// Two-channel safety monitor: start qualification, outputs and lamps.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "sms_map.svh"
module sms_top import sms_pkg::*; #(
  parameter int TICK_CYCLES = `SMS_TICK_NS / `SMS_CLK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        channel_a_input,
  input  wire logic        channel_b_input,
  input  wire logic        start_button_input,
  input  wire logic        feedback_loop_input,
  input  wire logic        release_input,
  input  wire logic [3:0]  mode_selector,
  input  wire logic [3:0]  time_selector,
  output logic             immediate_output_a,
  output logic             immediate_output_b,
  output logic             delayed_output_a,
  output logic             delayed_output_b,
  output logic             lamp_ready,
  output logic             lamp_chan_a,
  output logic             lamp_chan_b,
  output logic             lamp_imm,
  output logic             lamp_dly,
  output logic             lamp_fault
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  generate
    if (TICK_CYCLES < 2) begin : g_chk
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  function automatic logic in_set(input logic [3:0] m,
                                  input logic [15:0] set);
    in_set = set[m];
  endfunction
  function automatic logic [15:0] dly_ms(input logic [3:0] s);
    logic [255:0] t;
    t = `SMS_DLY_TAB;
    dly_ms = t[{s, 4'h0} +: 16];
  endfunction
  // Long and short counts per cause; unknown causes give zero.
  function automatic logic [7:0] code_of(input logic [4:0] c);
    case (c)
      5'h01: code_of = 8'h11;
      5'h02: code_of = 8'h12;
      5'h03: code_of = 8'h13;
      5'h04: code_of = 8'h15;
      5'h05: code_of = 8'h17;
      5'h06: code_of = 8'h19;
      5'h07: code_of = 8'h16;
      5'h08: code_of = 8'h18;
      5'h09: code_of = 8'h22;
      5'h0A: code_of = 8'h23;
      5'h0B: code_of = 8'h24;
      5'h0C: code_of = 8'h34;
      5'h0D: code_of = 8'h35;
      5'h0E: code_of = 8'h39;
      5'h0F: code_of = 8'h29;
      5'h10: code_of = 8'h31;
      5'h11: code_of = 8'h68;
      default: code_of = 8'h00;
    endcase
  endfunction

  logic [TW-1:0] tick_cnt_reg;
  logic          tick;
  logic [15:0]   quick_cnt_reg, slow_cnt_reg;
  logic          quick_reg, slow_reg;
  assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quick_cnt_reg <= 16'h0000;
      slow_cnt_reg  <= 16'h0000;
      quick_reg     <= 1'b0;
      slow_reg      <= 1'b0;
    end else if (tick) begin
      quick_cnt_reg <= quick_cnt_reg + 16'h0001;
      slow_cnt_reg  <= slow_cnt_reg + 16'h0001;
      if (quick_cnt_reg == `SMS_QUICK_MS - 16'h0001) begin
        quick_cnt_reg <= 16'h0000;
        quick_reg     <= !quick_reg;
      end
      if (slow_cnt_reg == `SMS_SLOW_MS - 16'h0001) begin
        slow_cnt_reg <= 16'h0000;
        slow_reg     <= !slow_reg;
      end
    end
  end

  sms_state_e  state_reg;
  logic [31:0] ctrl_reg;
  logic [4:0]  fault_reg;
  logic [3:0]  app_mode_reg, app_time_reg;
  logic        moved_reg, sync_err_reg, a_seen_reg, b_seen_reg;
  logic        start_d_reg;
  logic [15:0] tmr_ms_reg, sync_ms_reg, cfg_ms_reg, press_ms_reg;
  logic        mon, xw_en, sync_en, nc_no, mode_ok, a_cl, b_cl;
  logic        ctrl_valid, ready, start_req, mismatch, wait_start;
  logic        press_ok, drop_req;
  logic [4:0]  hw_cause;
  // Positions 1-5 watch the trailing edge, 6-10 start on level.
  assign mon     = (mode_selector >= 4'h1) &&
                   (mode_selector <= `SMS_MODE_MON_MAX);
  assign xw_en   = in_set(mode_selector, 16'h01E6);
  assign sync_en = in_set(mode_selector, 16'h02AA);
  assign nc_no   = in_set(mode_selector, 16'h0060);
  assign mode_ok = (mode_selector >= 4'h1) &&
                   (mode_selector <= `SMS_MODE_MAX);
  assign a_cl    = channel_a_input;
  assign b_cl    = channel_b_input ^ nc_no;
  assign ctrl_valid = ctrl_reg[`SMS_CTRL_VALID];
  assign mismatch = ctrl_valid && ((mode_selector != ctrl_reg[3:0]) ||
                    (time_selector != ctrl_reg[7:4]));
  assign wait_start = (state_reg == ST_IDLE) && a_cl && b_cl &&
                      !sync_err_reg;
  assign ready = wait_start && a_seen_reg && b_seen_reg && ctrl_valid &&
                 mode_ok && feedback_loop_input && release_input;
  assign press_ok = (press_ms_reg >= `SMS_ACT_MIN_MS) &&
                    (press_ms_reg <= `SMS_ACT_MAX_MS);
  assign start_req = mon ?
    (start_d_reg && !start_button_input && press_ok) :
    start_button_input;
  assign drop_req = !(a_cl && b_cl) || !release_input;
  assign hw_cause = (cfg_ms_reg >= `SMS_CFG_MS) ? `SMS_F_CFG :
    (!mode_ok && mode_selector != `SMS_MODE_CFG) ? `SMS_F_SEL : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d_reg  <= 1'b0;
      press_ms_reg <= 16'h0000;
      cfg_ms_reg   <= 16'h0000;
    end else begin
      start_d_reg <= start_button_input;
      if (!start_button_input) begin
        press_ms_reg <= 16'h0000;
      end else if (tick && press_ms_reg != 16'hFFFF) begin
        press_ms_reg <= press_ms_reg + 16'h0001;
      end
      if (mode_selector != `SMS_MODE_CFG) begin
        cfg_ms_reg <= 16'h0000;
      end else if (tick && cfg_ms_reg < `SMS_CFG_MS) begin
        cfg_ms_reg <= cfg_ms_reg + 16'h0001;
      end
    end
  end

  // Window runs while exactly one channel is closed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ms_reg  <= 16'h0000;
      sync_err_reg <= 1'b0;
    end else begin
      if (!a_cl && !b_cl) begin
        sync_err_reg <= 1'b0;
      end else if (sync_en && sync_ms_reg >= `SMS_SYNC_MS) begin
        sync_err_reg <= 1'b1;
      end
      if (a_cl == b_cl) begin
        sync_ms_reg <= 16'h0000;
      end else if (tick && sync_ms_reg < `SMS_SYNC_MS) begin
        sync_ms_reg <= sync_ms_reg + 16'h0001;
      end
    end
  end

  // A restart needs both channels to have opened since the last run.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_seen_reg <= 1'b1;
      b_seen_reg <= 1'b1;
    end else if (state_reg == ST_IDLE && ready && start_req) begin
      a_seen_reg <= 1'b0;
      b_seen_reg <= 1'b0;
    end else begin
      a_seen_reg <= a_seen_reg || !a_cl;
      b_seen_reg <= b_seen_reg || !b_cl;
    end
  end

  // First fault wins and stays until power is cycled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= 5'h00;
    end else if (fault_reg == 5'h00) begin
      if (hw_cause != 5'h00) begin
        fault_reg <= hw_cause;
      end else if (psel && penable && pwrite &&
                   paddr == `SMS_ADDR_FAULT &&
                   pwdata[4:0] != 5'h00 && pwdata[4:0] <= `SMS_F_LAST &&
                   (pwdata[4:0] != `SMS_F_XW || xw_en)) begin
        fault_reg <= pwdata[4:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_TEST;
      tmr_ms_reg   <= 16'h0000;
      moved_reg    <= 1'b0;
      app_mode_reg <= 4'h0;
      app_time_reg <= 4'h0;
    end else begin
      if (tick && tmr_ms_reg != 16'hFFFF) begin
        tmr_ms_reg <= tmr_ms_reg + 16'h0001;
      end
      case (state_reg)
        ST_TEST: begin
          app_mode_reg <= mode_selector;
          app_time_reg <= time_selector;
          if (tmr_ms_reg >= `SMS_TEST_MS) begin
            state_reg <= mismatch ? ST_CHANGED : ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (ready && start_req) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          tmr_ms_reg <= 16'h0000;
          if (drop_req) begin
            state_reg <= (dly_ms(app_time_reg) == 16'h0000) ?
                         ST_IDLE : ST_DROP;
          end
        end
        ST_DROP: begin
          if (tmr_ms_reg >= dly_ms(app_time_reg)) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_CHANGED, ST_FAULT: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= ST_FAULT;
        end
      endcase
      if (state_reg != ST_TEST && state_reg != ST_FAULT) begin
        if (fault_reg != 5'h00) begin
          state_reg <= ST_FAULT;
        end else if (state_reg != ST_CHANGED && mode_ok &&
                     (mode_selector != app_mode_reg ||
                      time_selector != app_time_reg)) begin
          state_reg <= ST_CHANGED;
          moved_reg <= 1'b1;
        end
      end
    end
  end

  sms_flash_e fl_state_reg;
  logic [3:0] fl_cnt_reg;
  logic [15:0] fl_ms_reg, fl_dur;
  logic [3:0] n_long, n_short;
  logic       fl_last;
  logic [7:0] fl_code;
  assign fl_code = code_of(fault_reg);
  assign n_long  = fl_code[7:4];
  assign n_short = fl_code[3:0];
  always_comb begin
    fl_last = 1'b0;
    fl_dur  = `SMS_GAP_MS;
    case (fl_state_reg)
      FL_LONG_ON:   fl_dur = `SMS_LONG_MS;
      FL_SHORT_ON:  fl_dur = `SMS_SHORT_MS;
      FL_LONG_OFF: begin
        fl_last = (fl_cnt_reg + 4'h1 == n_long);
        fl_dur  = fl_last ? `SMS_GROUP_MS : `SMS_GAP_MS;
      end
      FL_SHORT_OFF: begin
        fl_last = (fl_cnt_reg + 4'h1 == n_short);
        fl_dur  = fl_last ? `SMS_PAUSE_MS : `SMS_GAP_MS;
      end
      default: fl_dur = `SMS_GAP_MS;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_state_reg <= FL_LONG_ON;
      fl_cnt_reg   <= 4'h0;
      fl_ms_reg    <= 16'h0000;
    end else if (state_reg != ST_FAULT) begin
      fl_state_reg <= FL_LONG_ON;
      fl_cnt_reg   <= 4'h0;
      fl_ms_reg    <= 16'h0000;
    end else if (tick) begin
      fl_ms_reg <= fl_ms_reg + 16'h0001;
      if (fl_ms_reg + 16'h0001 >= fl_dur) begin
        fl_ms_reg <= 16'h0000;
        case (fl_state_reg)
          FL_LONG_ON:  fl_state_reg <= FL_LONG_OFF;
          FL_SHORT_ON: fl_state_reg <= FL_SHORT_OFF;
          FL_LONG_OFF: begin
            fl_cnt_reg   <= fl_last ? 4'h0 : fl_cnt_reg + 4'h1;
            fl_state_reg <= fl_last ? FL_SHORT_ON : FL_LONG_ON;
          end
          default: begin
            fl_cnt_reg   <= fl_last ? 4'h0 : fl_cnt_reg + 4'h1;
            fl_state_reg <= fl_last ? FL_LONG_ON : FL_SHORT_ON;
          end
        endcase
      end
    end
  end

  logic run_on, dly_on;
  logic [5:0] lamps_next;  // ready, a, b, imm, dly, fault
  assign run_on = (state_reg == ST_RUN);
  assign dly_on = run_on || (state_reg == ST_DROP);
  always_comb begin
    case (state_reg)
      ST_TEST:    lamps_next = 6'h3F;
      ST_CHANGED: lamps_next = moved_reg ?
        {1'b0, {5{quick_reg}}} :
        {{5{quick_reg}}, 1'b0};
      ST_FAULT:   lamps_next = {5'h00,
        fl_state_reg == FL_LONG_ON || fl_state_reg == FL_SHORT_ON};
      default: begin
        lamps_next[5] = ctrl_valid ? 1'b1 : slow_reg;
        lamps_next[4] = sync_err_reg ? quick_reg :
          (!b_seen_reg && !dly_on) ? slow_reg : a_cl;
        lamps_next[3] = sync_err_reg ? quick_reg :
          (!a_seen_reg && !dly_on) ? slow_reg : b_cl;
        lamps_next[2] = run_on ? 1'b1 : !release_input ? quick_reg :
          (wait_start || !feedback_loop_input) ? slow_reg :
          1'b0;
        lamps_next[1] = dly_on ? 1'b1 : !release_input ? quick_reg :
          (wait_start || !feedback_loop_input) ? slow_reg :
          1'b0;
        lamps_next[0] = 1'b0;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lamp_ready, lamp_chan_a, lamp_chan_b} <= 3'h0;
      {lamp_imm, lamp_dly, lamp_fault}       <= 3'h0;
      immediate_output_a <= 1'b0;
      immediate_output_b <= 1'b0;
      delayed_output_a   <= 1'b0;
      delayed_output_b   <= 1'b0;
    end else begin
      {lamp_ready, lamp_chan_a, lamp_chan_b,
       lamp_imm, lamp_dly, lamp_fault} <= lamps_next;
      immediate_output_a <= run_on;
      immediate_output_b <= run_on;
      delayed_output_a   <= dly_on;
      delayed_output_b   <= dly_on;
    end
  end

  // Read data is captured in the setup phase so no wait state is needed.
  logic err_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SMS_CTRL_RST;
      prdata   <= 32'h0000_0000;
      err_reg  <= 1'b0;
    end else begin
      if (psel && penable && pwrite && paddr == `SMS_ADDR_CTRL) begin
        ctrl_reg <= {23'h00_0000, pwdata[8:0]};
      end
      if (psel && !penable) begin
        err_reg <= 1'b0;
        prdata  <= 32'h0000_0000;
        case (paddr)
          `SMS_ADDR_CTRL:   prdata <= ctrl_reg;
          `SMS_ADDR_FAULT:  prdata <= {27'h000_0000, fault_reg};
          `SMS_ADDR_STATUS: prdata <= {18'h0_0000, lamps_next,
            moved_reg, sync_err_reg, dly_on, run_on, 1'b0, state_reg};
          default:          err_reg <= 1'b1;
        endcase
      end
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_release_lost;
    run_on && release_input && a_cl && b_cl ##1 !release_input;
  endsequence
  sequence s_long_press;
    mon && start_d_reg && !start_button_input &&
    press_ms_reg > `SMS_ACT_MAX_MS;
  endsequence
  AST_IMM_OFF_ON_RELEASE: assert property (
    s_release_lost |=> ##1 !immediate_output_a && !immediate_output_b)
    else $error("immediate outputs stayed on after release loss");
  AST_DLY_HOLDS: assert property (
    s_release_lost ##0 dly_ms(app_time_reg) != 16'h0000
    |=> delayed_output_a ##1 delayed_output_b)
    else $error("delayed outputs dropped without delay");
  AST_NO_LONG_START: assert property (
    (s_long_press and state_reg == ST_IDLE) |=> !run_on [*2])
    else $error("overlong press started outputs");
  AST_NO_START_ON_PRESS: assert property (
    mon && state_reg == ST_IDLE && $rose(start_button_input)
    |=> !run_on)
    else $error("monitored mode started on press");
  AST_AUTOSTART: assert property (
    !mon && ready && start_button_input |=> ##1 immediate_output_a)
    else $error("autostart did not start");
  AST_FAULT_OFF: assert property (
    state_reg == ST_FAULT |=> !immediate_output_a && !delayed_output_b)
    else $error("outputs on while in fault");
  AST_IMM_LAMP: assert property (
    run_on |=> lamp_imm && immediate_output_a)
    else $error("immediate lamp not steady with outputs on");
  AST_DLY_LAMP: assert property (
    dly_on |=> lamp_dly && delayed_output_a)
    else $error("delayed lamp not steady with outputs on");
  AST_READY_LAMP: assert property (
    state_reg == ST_IDLE && ctrl_valid |=> lamp_ready)
    else $error("ready lamp not steady");
  AST_CFG_FAULT: assert property (
    cfg_ms_reg >= `SMS_CFG_MS && fault_reg == 5'h00
    |=> fault_reg == `SMS_F_CFG)
    else $error("configuration timeout not latched");
endmodule

// ==== sms_contactor.sv ====
// Downstream contactor pair whose auxiliary contacts form the feedback loop.
`timescale 1ns/1ps
module sms_contactor #(
  parameter int LAG = 3
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic coil_a,
  input  wire logic coil_b,
  output logic      feedback_loop_input
);
  logic [7:0] lag_reg;

  // The loop only closes once both coils have dropped out for LAG cycles,
  // so a restart straight after a stop is held off as real contactors do.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lag_reg <= '0;
    end else if (coil_a || coil_b) begin
      lag_reg <= 8'(LAG);
    end else if (lag_reg != 0) begin
      lag_reg <= lag_reg - 8'h01;
    end
  end
  assign feedback_loop_input = (lag_reg == 0) && !coil_a && !coil_b;
endmodule

// ==== tb.sv ====
// Self-checking bench for the safety monitor start and lamp logic.
`timescale 1ns/1ps
`include "sms_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
  localparam int TK = 4;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er, ch_a = 0, ch_b = 0, start = 0;
  logic        rel = 1, fb, ia, ib, da, db;
  logic [3:0]  mode = 4'h1, tsel = 4'h0;
  logic        l_rdy, l_a, l_b, l_imm, l_dly, l_flt;
  int          err_total = 0, comparisons = 0, n1, n2;

  always #2.5 pclk = ~pclk;

  sms_top #(.TICK_CYCLES(TK)) sms_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_a_input(ch_a),
    .channel_b_input(ch_b), .start_button_input(start),
    .feedback_loop_input(fb), .release_input(rel), .mode_selector(mode),
    .time_selector(tsel), .immediate_output_a(ia),
    .immediate_output_b(ib), .delayed_output_a(da),
    .delayed_output_b(db), .lamp_ready(l_rdy), .lamp_chan_a(l_a),
    .lamp_chan_b(l_b), .lamp_imm(l_imm), .lamp_dly(l_dly),
    .lamp_fault(l_flt));

  sms_contactor sms_contactor_inst (
    .pclk(pclk), .presetn(presetn), .coil_a(ia), .coil_b(ib),
    .feedback_loop_input(fb));

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic do_reset(input logic [3:0] m);
    @(posedge pclk);
    presetn <= 0; mode <= m; ch_a <= 0; ch_b <= 0; start <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
  endtask

  task automatic t_lamp_test();
    repeat (10) @(posedge pclk);
    `CHK("lamps", 6'h3F, {l_rdy, l_a, l_b, l_imm, l_dly, l_flt})
    `CHK("out", 2'b00, {ia, da})
    apb(0, `SMS_ADDR_CTRL, '0);
    `CHK("ctrl", `SMS_CTRL_RST, rd)
    apb(0, 12'h0FC, '0);
    `CHK("slverr", 1'b1, er)
    repeat (2100) @(posedge pclk);
    `CHK("ready", 1'b1, l_rdy)
    repeat (700) @(posedge pclk);
    `CHK("ready2", 1'b1, l_rdy)
  endtask

  task automatic close_and_press(input int cyc);
    ch_a <= 1; ch_b <= 1;
    repeat (20) @(posedge pclk);
    start <= 1;
    repeat (cyc) @(posedge pclk);
    `CHK("held", 1'b0, ia)
    start <= 0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_monitored();
    close_and_press(40);
    `CHK("short", 1'b0, ia)
    ch_a <= 0; ch_b <= 0;
    repeat (20) @(posedge pclk);
    close_and_press(400);
    `CHK("imm", 2'b11, {ia, ib})
    `CHK("dly", 2'b11, {da, db})
    `CHK("limm", 1'b1, l_imm)
    `CHK("lch", 2'b11, {l_a, l_b})
    `CHK("ldly", 1'b1, l_dly)
    rel <= 0;
    repeat (6) @(posedge pclk);
    `CHK("off", 4'h0, {ia, ib, da, db})
    rel <= 1; // Kept high whenever no stop is wanted.
    ch_a <= 0; ch_b <= 0;
  endtask

  task automatic t_moved();
    mode <= 4'h3;
    repeat (20) @(posedge pclk);
    apb(0, `SMS_ADDR_STATUS, '0);
    `CHK("state", 3'h4, rd[2:0])
    `CHK("moved", 1'b1, rd[7])
  endtask

  task automatic t_autostart();
    tsel <= 4'h1;
    do_reset(4'h7);
    apb(1, `SMS_ADDR_CTRL, 32'h0000_0117);
    repeat (2100) @(posedge pclk);
    ch_a <= 1; ch_b <= 1;
    repeat (20) @(posedge pclk);
    `CHK("wait", 1'b0, ia)
    start <= 1;
    repeat (6) @(posedge pclk);
    `CHK("auto", 1'b1, ia)
    start <= 0;
    rel <= 0;
    repeat (6) @(posedge pclk);
    `CHK("imm_off", 2'b00, {ia, ib})
    `CHK("dly_hold", 2'b11, {da, db})
    // Step 1 is 500 ticks, so the delayed pair drops near 2000 cycles.
    repeat (1984) @(posedge pclk);
    `CHK("dly_late", 2'b11, {da, db})
    repeat (20) @(posedge pclk);
    `CHK("dly_off", 2'b00, {da, db})
    rel <= 1;
    tsel <= 4'h0;
  endtask

  task automatic pulse(output int n);
    n = 0;
    while (l_flt !== 1'b1) @(posedge pclk);
    while (l_flt === 1'b1) begin
      n++;
      @(posedge pclk);
    end
    n = (n + TK / 2) / TK;
  endtask

  task automatic t_fault_code();
    do_reset(4'h1);
    repeat (2100) @(posedge pclk);
    apb(1, `SMS_ADDR_FAULT, 32'(`SMS_F_UV));
    apb(1, `SMS_ADDR_FAULT, 32'(`SMS_F_OV));
    apb(0, `SMS_ADDR_FAULT, '0);
    `CHK("cause", `SMS_F_UV, rd[4:0])
    while (l_flt === 1'b1) @(posedge pclk);
    pulse(n1);
    pulse(n2);
    // The lamp is already lit on arrival, so the short flash comes first.
    `CHK("long", 600, n2)
    `CHK("short", 200, n1)
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(4'h1);
    t_lamp_test();
    t_monitored();
    t_moved();
    t_autostart();
    t_fault_code();
    results();
  end

  // Allows well over the expected run of about 31000 cycles.
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    results();
  end
endmodule
